/* File: rtl/fmps_consts.svh */
`ifndef FMPS_CONSTS_SVH
`define FMPS_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FMPS_OFS_CTRL      8'h00
`define FMPS_OFS_MATSEL    8'h04
`define FMPS_OFS_DFPROT    8'h08
`define FMPS_OFS_CMD       8'h0C
`define FMPS_OFS_STATUS    8'h10
`define FMPS_OFS_LOCKRD    8'h14

// ****************************************
// Field positions
// ****************************************
`define FMPS_CTRL_CMDEN    0
`define FMPS_CTRL_LOCKDIS  1
`define FMPS_DFP_LO        0
`define FMPS_DFP_HI        1
`define FMPS_CMD_BLK_LSB   8
`define FMPS_LOCKRD_BIT    14

// ****************************************
// Codes and reset values
// ****************************************
`define FMPS_MAT_BOOT      8'hAA
`define FMPS_MAT_USER      8'h00
`define FMPS_CODE_READ     8'hFF
`define FMPS_CODE_CLEAR    8'h50
`define FMPS_CODE_LOCKRD   8'h71
`define FMPS_CODE_PROG     8'h41
`define FMPS_CODE_ERASE    8'h20
`define FMPS_CODE_LOCKPROG 8'h77
`define FMPS_ABR_SYNC      8'h00
`define FMPS_ABR_ACK       8'h55
`define FMPS_ABR_LOW_BITS  16'h0009
`define FMPS_DF_BLK_LO     3'h6
`define FMPS_DF_BLK_HI     3'h7
`define FMPS_BOOT_LIMIT    17'h04000
`define FMPS_CTRL_RST      1'h0
`define FMPS_DFP_RST       1'h0
`define FMPS_LOCK_RST      1'h1

// ****************************************
// Timing
// ****************************************
`define FMPS_CLK_PS        25000
`define FMPS_SWITCH_NS     100
`define FMPS_CHECK_NS      1000
`define FMPS_SWITCH_CYC    ((`FMPS_SWITCH_NS * 1000 + `FMPS_CLK_PS - 1) / `FMPS_CLK_PS)
`define FMPS_CHECK_CYC     ((`FMPS_CHECK_NS * 1000 + `FMPS_CLK_PS - 1) / `FMPS_CLK_PS)

`endif

/* File: rtl/fmps_pkg.sv */
package fmps_pkg;
  typedef logic [2:0] fmps_blk_t;
  typedef logic [7:0] fmps_code_t;
  typedef enum {
    FMPS_AB_IDLE,
    FMPS_AB_WAIT,
    FMPS_AB_MEASURE,
    FMPS_AB_SEND,
    FMPS_AB_RXWAIT,
    FMPS_AB_RXBITS,
    FMPS_AB_DONE
  } fmps_abr_state_t;
endpackage : fmps_pkg

/* File: rtl/fmps_abr_if.sv */
`timescale 1ns/1ps
interface fmps_abr_if;
  logic        run;
  logic        rx;
  logic        tx;
  logic        done;
  logic [15:0] divisor;
  modport ctl (output run, output rx, input tx, input done, input divisor);
  modport eng (input run, input rx, output tx, output done, output divisor);
endinterface : fmps_abr_if

/* File: rtl/fmps_abr.sv */
`timescale 1ns/1ps
`include "fmps_consts.svh"
module fmps_abr
  import fmps_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // Controller link
  fmps_abr_if.eng   abr
);

  fmps_abr_state_t st;
  logic [15:0]     cnt;
  logic [15:0]     div;
  logic [3:0]      bitn;
  logic [9:0]      shreg;

  // ****************************************
  // Rate measurement, end sign, answer check
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !abr.run) begin
      st    <= FMPS_AB_IDLE;
      cnt   <= 16'h0000;
      div   <= 16'h0000;
      bitn  <= 4'h0;
      shreg <= 10'h3FF;
    end else begin
      case (st)
        FMPS_AB_IDLE: st <= FMPS_AB_WAIT;
        FMPS_AB_WAIT: if (!abr.rx) begin
          cnt <= 16'h0001;
          st  <= FMPS_AB_MEASURE;
        end
        FMPS_AB_MEASURE: if (!abr.rx) begin
          cnt <= cnt + 16'h0001;
        end else if (cnt >= `FMPS_ABR_LOW_BITS) begin
          div   <= cnt / `FMPS_ABR_LOW_BITS;
          cnt   <= 16'h0000;
          bitn  <= 4'h0;
          shreg <= {1'b1, `FMPS_ABR_SYNC, 1'b0};
          st    <= FMPS_AB_SEND;
        end else begin
          st <= FMPS_AB_WAIT;
        end
        FMPS_AB_SEND: if (cnt == div - 16'h0001) begin
          cnt   <= 16'h0000;
          shreg <= {1'b1, shreg[9:1]};
          if (bitn == 4'h9) begin
            bitn <= 4'h0;
            st   <= FMPS_AB_RXWAIT;
          end else begin
            bitn <= bitn + 4'h1;
          end
        end else begin
          cnt <= cnt + 16'h0001;
        end
        FMPS_AB_RXWAIT: if (!abr.rx) begin
          cnt  <= div + (div >> 1);
          bitn <= 4'h0;
          st   <= FMPS_AB_RXBITS;
        end
        FMPS_AB_RXBITS: if (cnt == 16'h0000) begin
          cnt   <= div - 16'h0001;
          shreg <= {abr.rx, shreg[9:1]};
          bitn  <= bitn + 4'h1;
          if (bitn == 4'h8) begin
            st <= (abr.rx && shreg[9:2] == `FMPS_ABR_ACK) ? FMPS_AB_DONE : FMPS_AB_RXWAIT;
          end
        end else begin
          cnt <= cnt - 16'h0001;
        end
        FMPS_AB_DONE: st <= FMPS_AB_DONE;
        default: st <= FMPS_AB_IDLE;
      endcase
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      abr.tx      <= 1'b1;
      abr.done    <= 1'b0;
      abr.divisor <= 16'h0000;
    end else begin
      abr.tx      <= (st == FMPS_AB_SEND) ? shreg[0] : 1'b1;
      abr.done    <= (st == FMPS_AB_DONE);
      abr.divisor <= div;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_abr_idle_high;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (st != FMPS_AB_SEND) |=> abr.tx;
  endproperty
  a_abr_idle_high: assert property (p_abr_idle_high) else $error("tx not idle high");

  property p_abr_rate;
    @(posedge ref_clk_in) disable iff (sys_rst_in || !abr.run)
    (st == FMPS_AB_MEASURE && abr.rx && cnt >= 16'h0009) |=> (div == $past(cnt) / 16'h0009);
  endproperty
  a_abr_rate: assert property (p_abr_rate) else $error("divisor not low period over 9");

endmodule : fmps_abr

/* File: rtl/fmps_top.sv */
// Behaviour
// - Boot link frames: 8 data, 1 stop, no parity
// - Measure zero-byte low time, derive bit rate
// - Send zero end sign, expect 0x55 answer
// - Interrupts ignored throughout boot mode
// - User boot mat writable only in boot/programmer
// - Check routine after reset blocks all interrupts
// - Check end selects user boot mat, 0xAA
// - No return to boot mat after leaving in user boot mode
// - No mat access during a switch
// - Vector table follows the selected mat
// - Boot mat reads above 16 KB undefined
// - Boot mat selected disables program and erase outside boot/programmer mode
// - Command enable clear blocks all commands
// - Data flash protected per block, both bits all
// - Locked block refuses program and erase
// - Lock program clears bit, erase sets it
// - Lock disable unlocks all, erase sets bit
// - Lock read returns lock bit in bit 14
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "fmps_consts.svh"
module fmps_top
  import fmps_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Mode straps
  input  wire logic        boot_mode_in,
  input  wire logic        user_boot_mode_in,
  input  wire logic        programmer_mode_in,
  // Flash read monitor
  input  wire logic        flash_rd_valid_in,
  input  wire logic [16:0] flash_rd_addr_in,
  // Boot serial link
  input  wire logic        serial_rx_in,
  output logic             serial_tx_out,
  // Array sequencer and CPU side
  output logic             cmd_accept_out,
  output logic             cmd_reject_out,
  output logic [7:0]       cmd_op_out,
  output logic [2:0]       cmd_blk_out,
  output logic             irq_block_out,
  output logic             flash_access_block_out,
  output logic             vector_boot_mat_out,
  output logic             read_undef_out
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic fmps_mapped(input logic [7:0] a);
    case (a)
      `FMPS_OFS_CTRL, `FMPS_OFS_MATSEL, `FMPS_OFS_DFPROT,
      `FMPS_OFS_CMD, `FMPS_OFS_STATUS, `FMPS_OFS_LOCKRD: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : fmps_mapped

  function automatic logic fmps_is_array_cmd(input fmps_code_t c);
    return (c == `FMPS_CODE_PROG) || (c == `FMPS_CODE_ERASE) || (c == `FMPS_CODE_LOCKPROG);
  endfunction : fmps_is_array_cmd

  // ****************************************
  // State
  // ****************************************
  logic        command_enable_bit;
  logic        lock_disable_bit;
  logic        dflash_protect_bit_hi;
  logic        dflash_protect_bit_lo;
  logic [7:0]  mat_select_reg;
  logic [7:0]  lock_bits;
  logic        active_boot;
  logic        boot_locked;
  logic [3:0]  switch_cnt;
  logic        switching;
  logic        init_done;
  logic        check_busy;
  logic [7:0]  check_cnt;
  logic        lk_mode;
  fmps_blk_t   lk_blk;
  logic        last_reject;
  logic [31:0] rd_mux;

  fmps_abr_if abr_link ();

  fmps_abr u_abr (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .abr        (abr_link.eng)
  );

  // ****************************************
  // APB decode
  // ****************************************
  logic       apb_take;
  logic       wr_go;
  logic       cmd_go;
  fmps_code_t cmd_code;
  fmps_blk_t  cmd_blk;
  logic       df_hit;
  logic       cmd_permit;
  logic [7:0] mat_val;
  logic       mat_wr_ok;

  assign apb_take = psel_in && penable_in && !pready_out;
  assign wr_go    = psel_in && penable_in && pready_out && pwrite_in;
  assign cmd_go   = wr_go && (paddr_in == `FMPS_OFS_CMD);
  assign cmd_code = pwdata_in[7:0];
  assign cmd_blk  = pwdata_in[`FMPS_CMD_BLK_LSB +: 3];
  assign mat_val  = pwdata_in[7:0];
  assign switching = (switch_cnt != 4'h0);

  assign df_hit = ((cmd_blk == `FMPS_DF_BLK_LO) && dflash_protect_bit_lo)
               || ((cmd_blk == `FMPS_DF_BLK_HI) && dflash_protect_bit_hi);

  assign cmd_permit = command_enable_bit && !switching && !check_busy
                   && (!active_boot || boot_mode_in || programmer_mode_in)
                   && !df_hit
                   && (lock_bits[cmd_blk] || lock_disable_bit
                       || (cmd_code == `FMPS_CODE_LOCKPROG));

  assign mat_wr_ok = wr_go && (paddr_in == `FMPS_OFS_MATSEL) && !switching && !check_busy
                  && (((mat_val == `FMPS_MAT_BOOT) && !active_boot && !boot_locked)
                      || ((mat_val == `FMPS_MAT_USER) && active_boot));

  // ****************************************
  // APB answer
  // ****************************************
  always_comb begin
    case (paddr_in)
      `FMPS_OFS_CTRL:   rd_mux = {30'h0, lock_disable_bit, command_enable_bit};
      `FMPS_OFS_MATSEL: rd_mux = {24'h0, mat_select_reg};
      `FMPS_OFS_DFPROT: rd_mux = {30'h0, dflash_protect_bit_hi, dflash_protect_bit_lo};
      `FMPS_OFS_CMD:    rd_mux = {21'h0, cmd_blk_out, cmd_op_out};
      `FMPS_OFS_STATUS: rd_mux = {abr_link.divisor, 10'h0, last_reject, lk_mode,
                                  abr_link.done, check_busy, switching, active_boot};
      `FMPS_OFS_LOCKRD: rd_mux = {17'h0, lk_mode && lock_bits[lk_blk], 14'h0};
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_take;
      if (apb_take) begin
        prdata_out  <= pwrite_in ? 32'h0 : rd_mux;
        pslverr_out <= !fmps_mapped(paddr_in);
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      command_enable_bit    <= `FMPS_CTRL_RST;
      lock_disable_bit      <= `FMPS_CTRL_RST;
      dflash_protect_bit_hi <= `FMPS_DFP_RST;
      dflash_protect_bit_lo <= `FMPS_DFP_RST;
    end else if (wr_go) begin
      if (paddr_in == `FMPS_OFS_CTRL) begin
        command_enable_bit <= pwdata_in[`FMPS_CTRL_CMDEN];
        lock_disable_bit   <= pwdata_in[`FMPS_CTRL_LOCKDIS];
      end
      if (paddr_in == `FMPS_OFS_DFPROT) begin
        dflash_protect_bit_hi <= pwdata_in[`FMPS_DFP_HI];
        dflash_protect_bit_lo <= pwdata_in[`FMPS_DFP_LO];
      end
    end
  end

  // ****************************************
  // Reset check routine
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      init_done  <= 1'b0;
      check_busy <= 1'b0;
      check_cnt  <= 8'h00;
    end else if (!init_done) begin
      init_done  <= 1'b1;
      check_busy <= user_boot_mode_in;
      check_cnt  <= 8'(`FMPS_CHECK_CYC);
    end else if (check_busy) begin
      check_cnt <= check_cnt - 8'h01;
      if (check_cnt == 8'h01) begin
        check_busy <= 1'b0;
      end
    end
  end

  // ****************************************
  // Mat selection and switching
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mat_select_reg <= `FMPS_MAT_USER;
      active_boot    <= 1'b0;
      boot_locked    <= 1'b0;
      switch_cnt     <= 4'h0;
    end else if (check_busy && check_cnt == 8'h01) begin
      mat_select_reg <= `FMPS_MAT_BOOT;
      active_boot    <= 1'b1;
    end else if (mat_wr_ok) begin
      mat_select_reg <= mat_val;
      switch_cnt     <= 4'(`FMPS_SWITCH_CYC);
      if (mat_val == `FMPS_MAT_USER && user_boot_mode_in) begin
        boot_locked <= 1'b1;
      end
    end else if (switching) begin
      switch_cnt <= switch_cnt - 4'h1;
      if (switch_cnt == 4'h1) begin
        active_boot <= (mat_select_reg == `FMPS_MAT_BOOT);
      end
    end
  end

  // ****************************************
  // Lock bits, one per block
  // ****************************************
  generate
    for (genvar g = 0; g < 8; g++) begin : g_lock
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          lock_bits[g] <= `FMPS_LOCK_RST;
        end else if (cmd_go && cmd_permit && cmd_blk == 3'(g)) begin
          if (cmd_code == `FMPS_CODE_LOCKPROG) begin
            lock_bits[g] <= 1'b0;
          end else if (cmd_code == `FMPS_CODE_ERASE) begin
            lock_bits[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Command issue and lock read mode
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cmd_accept_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      cmd_op_out     <= 8'h00;
      cmd_blk_out    <= 3'h0;
      lk_mode        <= 1'b0;
      lk_blk         <= 3'h0;
      last_reject    <= 1'b0;
    end else begin
      cmd_accept_out <= cmd_go && fmps_is_array_cmd(cmd_code) && cmd_permit;
      cmd_reject_out <= cmd_go && fmps_is_array_cmd(cmd_code) && !cmd_permit;
      if (cmd_go) begin
        cmd_op_out  <= cmd_code;
        cmd_blk_out <= cmd_blk;
        last_reject <= fmps_is_array_cmd(cmd_code) && !cmd_permit;
        if (command_enable_bit) begin
          if (cmd_code == `FMPS_CODE_LOCKRD) begin
            lk_mode <= 1'b1;
            lk_blk  <= cmd_blk;
          end else begin
            lk_mode <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  assign abr_link.rx = serial_rx_in;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      abr_link.run           <= 1'b0;
      serial_tx_out          <= 1'b1;
      irq_block_out          <= 1'b1;
      flash_access_block_out <= 1'b0;
      vector_boot_mat_out    <= 1'b0;
      read_undef_out         <= 1'b0;
    end else begin
      abr_link.run           <= boot_mode_in;
      serial_tx_out          <= abr_link.tx;
      irq_block_out          <= boot_mode_in || check_busy || !init_done;
      flash_access_block_out <= switching || check_busy;
      vector_boot_mat_out    <= active_boot;
      read_undef_out         <= flash_rd_valid_in && active_boot
                                && (flash_rd_addr_in >= `FMPS_BOOT_LIMIT);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic lk_sel_bit;
  assign lk_sel_bit = lock_bits[lk_blk];

  property p_cmd_disabled;
    (cmd_go && !command_enable_bit) |=> !cmd_accept_out;
  endproperty
  a_cmd_disabled: assert property (p_cmd_disabled) else $error("command ran while disabled");

  property p_boot_mat_noprog;
    (cmd_go && active_boot && !boot_mode_in && !programmer_mode_in) |=> !cmd_accept_out;
  endproperty
  a_boot_mat_noprog: assert property (p_boot_mat_noprog) else $error("boot mat programmed");

  property p_locked_refuse;
    (cmd_go && cmd_code == `FMPS_CODE_ERASE && !lock_bits[cmd_blk] && !lock_disable_bit)
      |=> (cmd_reject_out && !cmd_accept_out);
  endproperty
  a_locked_refuse: assert property (p_locked_refuse) else $error("locked block accepted");

  property p_lockprog_clears;
    (cmd_go && cmd_permit && cmd_code == `FMPS_CODE_LOCKPROG) |=> !lock_bits[$past(cmd_blk)];
  endproperty
  a_lockprog_clears: assert property (p_lockprog_clears) else $error("lock bit not cleared");

  property p_lockdis_erase;
    (cmd_go && cmd_permit && lock_disable_bit && cmd_code == `FMPS_CODE_ERASE)
      |=> (cmd_accept_out && lock_bits[$past(cmd_blk)]);
  endproperty
  a_lockdis_erase: assert property (p_lockdis_erase) else $error("erase under disable failed");

  property p_df_protect;
    (cmd_go && dflash_protect_bit_hi && dflash_protect_bit_lo && cmd_blk[2:1] == 2'h3)
      |=> !cmd_accept_out;
  endproperty
  a_df_protect: assert property (p_df_protect) else $error("protected data flash written");

  property p_no_boot_return;
    boot_locked |-> (mat_select_reg != `FMPS_MAT_BOOT);
  endproperty
  a_no_boot_return: assert property (p_no_boot_return) else $error("boot mat reselected");

  property p_switch_block;
    mat_wr_ok |=> ##1 flash_access_block_out [*4] ##1 !flash_access_block_out;
  endproperty
  a_switch_block: assert property (p_switch_block) else $error("switch window wrong");

  property p_check_end_mat;
    $fell(check_busy) |-> (mat_select_reg == `FMPS_MAT_BOOT && active_boot);
  endproperty
  a_check_end_mat: assert property (p_check_end_mat) else $error("check end not on boot mat");

  property p_irq_block;
    (boot_mode_in || check_busy) |=> irq_block_out;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("interrupts not blocked");

  property p_lock_read;
    (apb_take && !pwrite_in && paddr_in == `FMPS_OFS_LOCKRD && lk_mode)
      |=> (prdata_out[14] == $past(lk_sel_bit));
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read bit wrong");

  property p_boot_undef;
    (flash_rd_valid_in && active_boot && flash_rd_addr_in[16:14] != 3'h0) |=> read_undef_out;
  endproperty
  a_boot_undef: assert property (p_boot_undef) else $error("boot mat overrun not flagged");

  property p_vector_follow;
    1'b1 |=> (vector_boot_mat_out == $past(active_boot));
  endproperty
  a_vector_follow: assert property (p_vector_follow) else $error("vector mat mismatch");

  c_abr_done:  cover property ($rose(abr_link.done));
  c_switch:    cover property ($rose(flash_access_block_out) && init_done && !check_busy);
  c_lock_read: cover property (apb_take && paddr_in == `FMPS_OFS_LOCKRD && lk_mode);
  c_reject:    cover property (cmd_reject_out);

endmodule : fmps_top

/* File: tb/fmps_host.sv */
`timescale 1ns/1ps
// ********************
// Boot link host model
// ********************
module fmps_host #(
  parameter int BIT = 2083
) (
  // Clock and control
  input  wire logic ref_clk_in,
  input  wire logic start_in,
  // Serial lines
  output logic      rx_out,
  input  wire logic tx_in,
  // Result
  output logic      ok_out
);
  logic [9:0] frm;
  initial begin
    rx_out = 1'b1;
    ok_out = 1'b0;
    wait (start_in === 1'b1);
    repeat (BIT) @(posedge ref_clk_in);
    rx_out <= 1'b0;
    repeat (9 * BIT) @(posedge ref_clk_in);
    rx_out <= 1'b1;
    while (tx_in !== 1'b0) @(posedge ref_clk_in);
    repeat (BIT / 2) @(posedge ref_clk_in);
    for (int i = 0; i < 10; i++) begin
      frm[i] = tx_in;
      repeat (BIT) @(posedge ref_clk_in);
    end
    if (frm === 10'h200) begin
      frm = 10'h2AA;
      for (int i = 0; i < 10; i++) begin
        rx_out <= frm[i];
        repeat (BIT) @(posedge ref_clk_in);
      end
      ok_out <= 1'b1;
    end
    // Bad end sign: no answer, boot mode must restart
  end
endmodule : fmps_host

/* File: tb/flash_mat_select_protection_bench.sv */
`timescale 1ns/1ps
`include "fmps_consts.svh"
module flash_mat_select_protection_bench
  import fmps_pkg::*;
;
  typedef struct packed {
    logic [1:0] ctrl;
    logic [1:0] dfp;
    fmps_code_t code;
    fmps_blk_t  blk;
    logic       acc;
  } fmps_row_t;
  fmps_row_t rows [9] = '{
    '{2'h0, 2'h0, 8'h41, 3'h0, 1'h0},
    '{2'h1, 2'h0, 8'h41, 3'h0, 1'h1},
    '{2'h1, 2'h1, 8'h41, 3'h6, 1'h0},
    '{2'h1, 2'h1, 8'h20, 3'h7, 1'h1},
    '{2'h1, 2'h3, 8'h20, 3'h7, 1'h0},
    '{2'h1, 2'h0, 8'h77, 3'h3, 1'h1},
    '{2'h1, 2'h0, 8'h41, 3'h3, 1'h0},
    '{2'h1, 2'h0, 8'h20, 3'h3, 1'h0},
    '{2'h3, 2'h0, 8'h41, 3'h3, 1'h1}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ps, pe, pw, rdy, err, lerr, boot, ub, rv, srx, stx, acc, rej;
  logic irqb, fab, vbm, rund, hgo, hok, a, pm, nak;
  logic [7:0]  pa, op;
  logic [2:0]  ob;
  logic [31:0] pd, pr, q;
  logic [16:0] ra;
  int n_fail = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;

  fmps_top DUT (
    .ref_clk_in(clk), .sys_rst_in(rst), .psel_in(ps), .penable_in(pe),
    .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd), .prdata_out(pr),
    .pready_out(rdy), .pslverr_out(err), .boot_mode_in(boot),
    .user_boot_mode_in(ub), .programmer_mode_in(pm),
    .flash_rd_valid_in(rv), .flash_rd_addr_in(ra), .serial_rx_in(srx),
    .serial_tx_out(stx), .cmd_accept_out(acc), .cmd_reject_out(rej),
    .cmd_op_out(op), .cmd_blk_out(ob), .irq_block_out(irqb),
    .flash_access_block_out(fab), .vector_boot_mat_out(vbm),
    .read_undef_out(rund));

  fmps_host host (.ref_clk_in(clk), .start_in(hgo), .rx_out(srx), .tx_in(stx), .ok_out(hok));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    ps <= 1'b1;
    pw <= wr;
    pa <= ad;
    pd <= d;
    @(posedge clk);
    pe <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = pr;
    lerr = err;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask : apb

  task cmd(input logic [7:0] c, input logic [2:0] b, output logic got);
    apb(1'b1, `FMPS_OFS_CMD, {21'h0, b, c}, q);
    got = 1'b0;
    nak = 1'b0;
    repeat (4) begin
      @(posedge clk);
      got = got | acc;
      nak = nak | rej;
    end
  endtask : cmd

  task rdmon(input logic [16:0] ad);
    @(posedge clk);
    rv <= 1'b1;
    ra <= ad;
    @(posedge clk);
    rv <= 1'b0;
    @(posedge clk);
  endtask : rdmon

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    summarize;
  end

  initial begin
    {ps, pe, pw, boot, rv, hgo, pm} <= '0;
    {pa, pd, ra} <= '0;
    ub <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk(irqb, 1);
    chk(fab, 1);
    repeat (50) @(posedge clk);
    chk(irqb, 0);
    apb(1'b0, `FMPS_OFS_MATSEL, 0, q);
    chk(q, 32'h000000AA);
    chk(vbm, 1);
    apb(1'b1, `FMPS_OFS_CTRL, 1, q);
    cmd(8'h41, 3'h0, a);
    chk(a, 0);
    chk(nak, 1);
    pm <= 1'b1;
    cmd(8'h41, 3'h0, a);
    chk(a, 1);
    pm <= 1'b0;
    rdmon(17'h04000);
    chk(rund, 1);
    rdmon(17'h03FFC);
    chk(rund, 0);
    apb(1'b1, `FMPS_OFS_MATSEL, 0, q);
    repeat (4) @(posedge clk);
    chk(fab, 1);
    repeat (8) @(posedge clk);
    chk(vbm, 0);
    apb(1'b1, `FMPS_OFS_MATSEL, 32'hAA, q);
    repeat (8) @(posedge clk);
    apb(1'b0, `FMPS_OFS_MATSEL, 0, q);
    chk(q, 0);
    foreach (rows[i]) begin
      apb(1'b1, `FMPS_OFS_CTRL, rows[i].ctrl, q);
      apb(1'b1, `FMPS_OFS_DFPROT, rows[i].dfp, q);
      cmd(rows[i].code, rows[i].blk, a);
      chk(a, rows[i].acc);
      chk(nak, !rows[i].acc);
    end
    cmd(8'h71, 3'h3, a);
    chk({ob, op}, {3'h3, `FMPS_CODE_LOCKRD});
    apb(1'b0, `FMPS_OFS_LOCKRD, 0, q);
    chk(q[14], 0);
    cmd(8'h20, 3'h3, a);
    chk(a, 1);
    apb(1'b1, `FMPS_OFS_CTRL, 1, q);
    cmd(8'h71, 3'h3, a);
    apb(1'b0, `FMPS_OFS_LOCKRD, 0, q);
    chk(q[14], 1);
    apb(1'b0, 8'h40, 0, q);
    chk(lerr, 1);
    apb(1'b1, `FMPS_OFS_CTRL, 0, q);
    cmd(8'h20, 3'h3, a);
    chk(a, 0);
    chk(nak, 1);
    boot <= 1'b1;
    repeat (4) @(posedge clk);
    chk(irqb, 1);
    chk(stx, 1);
    hgo <= 1'b1;
    for (int i = 0; i < 80000 && hok !== 1'b1; i++) @(posedge clk);
    chk(hok, 1);
    repeat (4166) @(posedge clk);
    apb(1'b0, `FMPS_OFS_STATUS, 0, q);
    chk(q[3], 1);
    chk(q[31:16], 16'h0823);
    summarize;
  end
endmodule : flash_mat_select_protection_bench
